// ---- design/nes_status_regs.svh ----
// Behaviour
// RL1: Second status word holds flags of 256-byte sectors 8 to 15, bytes 2048-4095.
// RL2: All sector flags read zero while correction type selects one code per page.
// RL3: Recoverable flag means one corrected error, or many when multiple flag set.
// RL4: Check byte flag sets on a single bit error inside stored ECC bytes.
// RL5: Software then reads the parity word; the set bit in low 24 bits locates it.
// RL6: Multiple flag sets when more than one error hits a sector, else stays zero.
// RL7: After writing a page main area, host copies parity content into spare area.
// RL8: Bit offset field gives the corrupted bit for a single error; undefined otherwise.
// RL9: Word field locates a single error in 8 or 16 bit words; undefined otherwise.
// RL10: Sector n uses nibble at 4*(n-8): recoverable, check byte, multiple, reserved.
// RL11: Correction type: 0 per page, 1 per 256 bytes, 2 per 512 bytes, 8-bit only.
`ifndef NES_STATUS_REGS_SVH
`define NES_STATUS_REGS_SVH

// Byte addresses on the APB
`define NES_ADDR_LOC 32'h400e002c
`define NES_ADDR_SR2 32'h400e0034
`define NES_ADDR_MODE 32'h400e0020

// Reset values
`define NES_RST_LOC 32'h00000000
`define NES_RST_SR2 32'h00000000
`define NES_RST_MODE 8'h00

// Nibble layout per sector
`define NES_NIB_W 4
`define NES_F_REC 0
`define NES_F_CHK 1
`define NES_F_MUL 2
`define NES_F_RSV 3
`define NES_SECTORS 8
`define NES_SECTOR_HI_BIT 3

// Location word layout
`define NES_BIT_LSB 0
`define NES_BIT_W 4
`define NES_WORD_LSB 4
`define NES_WORD_W 12
`define NES_CHK_W 24

// Mode register layout
`define NES_MODE_TYPE_LSB 0
`define NES_MODE_TYPE_W 2
`define NES_MODE_BUS16 4
`define NES_MODE_W 8

`endif

// ---- design/nes_pkg.sv ----
package nes_pkg;
    // Correction granularity of the ECC engine
    typedef enum logic [1:0]
    {
        one_code_per_page = 2'h0,
        one_code_per_256_bytes = 2'h1,
        one_code_per_512_bytes = 2'h2
    } nes_corr_e;
endpackage

// ---- design/nes_sector_flags.sv ----
`timescale 1ns/10ps
`include "nes_status_regs.svh"
module nes_sector_flags
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ev_valid,
    input wire logic ev_single,
    input wire logic ev_check,
    input wire logic ev_multi,
    input wire logic page_clear,
    input wire logic enabled,
    input wire logic [2:0] read_clear,
    output logic [`NES_NIB_W-1:0] flags
);
    logic rec_reg;
    logic chk_reg;
    logic mul_reg;
    logic rec_next;
    logic chk_next;
    logic mul_next;
    logic take;

    // Sets ignored while the page code is in use
    assign take = ev_valid & enabled;

    // Set beats clear so no event is lost to a read
    // RL3 recoverable covers single and multiple
    assign rec_next = (take & (ev_single | ev_multi)) ? 1'b1 :
        ((page_clear | read_clear[`NES_F_REC]) ? 1'b0 : rec_reg);
    // RL4 check byte error capture
    assign chk_next = (take & ev_check) ? 1'b1 :
        ((page_clear | read_clear[`NES_F_CHK]) ? 1'b0 : chk_reg);
    // RL6 multiple only on multiple errors
    assign mul_next = (take & ev_multi) ? 1'b1 :
        ((page_clear | read_clear[`NES_F_MUL]) ? 1'b0 : mul_reg);

    // Flag storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rec_reg <= 1'b0;
            chk_reg <= 1'b0;
            mul_reg <= 1'b0;
        end
        else
        begin
            rec_reg <= rec_next;
            chk_reg <= chk_next;
            mul_reg <= mul_next;
        end
    end

    // RL10 nibble packing, reserved bit zero
    // RL2 forced to zero in page mode
    always_comb
    begin
        flags = {`NES_NIB_W{1'b0}};
        flags[`NES_F_REC] = rec_reg & enabled;
        flags[`NES_F_CHK] = chk_reg & enabled;
        flags[`NES_F_MUL] = mul_reg & enabled;
    end
endmodule // nes_sector_flags

// ---- design/nes_status.sv ----
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "nes_status_regs.svh"
module nes_status
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic page_start,
    input wire logic res_valid,
    input wire logic [3:0] res_sector,
    input wire logic res_single,
    input wire logic res_check,
    input wire logic res_multi,
    input wire logic [`NES_BIT_W-1:0] res_bit,
    input wire logic [`NES_WORD_W-1:0] res_word,
    input wire logic [`NES_CHK_W-1:0] res_check_pos,
    output nes_pkg::nes_corr_e correction_type_select
);
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic pslverr_next;
    logic [`NES_MODE_W-1:0] mode_reg;
    logic [`NES_MODE_W-1:0] mode_next;
    nes_pkg::nes_corr_e corr_reg;
    nes_pkg::nes_corr_e corr_next;
    logic [31:0] loc_reg;
    logic [31:0] loc_next;
    logic [31:0] status_word;
    logic [`NES_SECTORS-1:0] rsv_bits;

    wire sel_loc = (paddr == `NES_ADDR_LOC);
    wire sel_sr2 = (paddr == `NES_ADDR_SR2);
    wire sel_mode = (paddr == `NES_ADDR_MODE);
    wire mapped = sel_loc | sel_sr2 | sel_mode;
    wire setup_ph = psel & ~penable;
    wire done = psel & penable & pready_reg;
    wire wr_done = done & pwrite;
    wire sr2_read_done = done & ~pwrite & sel_sr2;
    wire mode_wr = wr_done & sel_mode & pstrb[0];
    wire flags_on = (corr_reg != nes_pkg::one_code_per_page);
    wire sector_hit = res_valid & res_sector[`NES_SECTOR_HI_BIT];
    wire page_loc_upd = res_valid & ~res_multi & ~flags_on;

    // Bus answer: zero wait states, data latched in setup
    assign prdata_next = sel_loc ? loc_reg :
        (sel_sr2 ? status_word :
        (sel_mode ? {{(32-`NES_MODE_W){1'b0}}, mode_reg} : 32'h00000000));
    // Holes and writes to read-only words answer with an error
    assign pslverr_next = ~mapped | (pwrite & ~sel_mode);

    // Mode register write, low byte lane only
    assign mode_next = mode_wr ? pwdata[`NES_MODE_W-1:0] : mode_reg;

    // RL11 wide memory or undefined code falls back to page
    always_comb
    begin
        case (mode_reg[`NES_MODE_TYPE_LSB +: `NES_MODE_TYPE_W])
            2'h1:
                corr_next = mode_reg[`NES_MODE_BUS16] ? nes_pkg::one_code_per_page
                    : nes_pkg::one_code_per_256_bytes;
            2'h2:
                corr_next = mode_reg[`NES_MODE_BUS16] ? nes_pkg::one_code_per_page
                    : nes_pkg::one_code_per_512_bytes;
            default:
                corr_next = nes_pkg::one_code_per_page;
        endcase
    end

    // RL8 bit offset and RL9 word location of a single error
    // RL5 check byte errors leave the failing bit in the low 24 bits
    assign loc_next = page_start ? `NES_RST_LOC :
        (!page_loc_upd ? loc_reg :
        (res_check ? {{(32-`NES_CHK_W){1'b0}}, res_check_pos}
        : {{(32-`NES_WORD_W-`NES_BIT_W){1'b0}}, res_word, res_bit}));

    // Bus side flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= setup_ph ? prdata_next : prdata_reg;
            pready_reg <= setup_ph;
            pslverr_reg <= setup_ph ? pslverr_next : 1'b0;
        end
    end

    // Mode, effective type and location
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= `NES_RST_MODE;
            corr_reg <= nes_pkg::one_code_per_page;
            loc_reg <= `NES_RST_LOC;
        end
        else
        begin
            mode_reg <= mode_next;
            corr_reg <= corr_next;
            loc_reg <= loc_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign correction_type_select = corr_reg;

    // RL1 one flag cell per upper sector
    // Clear only the bits that were returned, so late events survive
    genvar gi;
    generate
        for (gi = 0; gi < `NES_SECTORS; gi++)
        begin : g_sector
            wire hit = sector_hit & (res_sector[2:0] == 3'(gi));
            wire [2:0] rd_clr = {3{sr2_read_done}} & prdata_reg[gi*`NES_NIB_W +: 3];
            nes_sector_flags u_flags
            (
                .pclk(pclk),
                .presetn(presetn),
                .ev_valid(hit),
                .ev_single(res_single),
                .ev_check(res_check),
                .ev_multi(res_multi),
                .page_clear(page_start),
                .enabled(flags_on),
                .read_clear(rd_clr),
                .flags(status_word[gi*`NES_NIB_W +: `NES_NIB_W])
            );
            assign rsv_bits[gi] = status_word[gi*`NES_NIB_W + `NES_F_RSV];
        end
    endgenerate

    // Checks on the flag, location, mode and bus behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire [2:0] ev_idx = res_sector[2:0];
    wire quiet = ~page_start & ~sr2_read_done & ~mode_wr;

    // Page mode hides every flag from software
    rd_zero_page_a: assert property ( // RL2
        (setup_ph && sel_sr2 && !flags_on) |=> (prdata == 32'h00000000))
        else $error("status word not zero in page mode");

    // Multiple error sets both recoverable and multiple
    multi_flags_a: assert property ( // RL3
        (sector_hit && res_multi && flags_on && quiet)
        |=> (status_word[$past(ev_idx)*4 + `NES_F_REC]
            && status_word[$past(ev_idx)*4 + `NES_F_MUL]))
        else $error("multiple error did not set its flags");

    // Check byte error reaches its own bit
    check_flag_a: assert property ( // RL4
        (sector_hit && res_check && flags_on && quiet)
        |=> status_word[$past(ev_idx)*4 + `NES_F_CHK])
        else $error("check byte flag not set");

    // Single error never raises the multiple flag
    single_no_mul_a: assert property ( // RL6
        (sector_hit && !res_multi && flags_on && quiet
            && !status_word[ev_idx*4 + `NES_F_MUL])
        |=> !status_word[$past(ev_idx)*4 + `NES_F_MUL])
        else $error("multiple flag set without multiple errors");

    // Corrupted bit offset follows the engine
    bit_offset_a: assert property ( // RL8
        (page_loc_upd && !res_check && !page_start)
        |=> (loc_reg[`NES_BIT_LSB +: `NES_BIT_W] == $past(res_bit)))
        else $error("bit offset not captured");

    // Word location follows the engine
    word_loc_a: assert property ( // RL9
        (page_loc_upd && !res_check && !page_start)
        |=> (loc_reg[`NES_WORD_LSB +: `NES_WORD_W] == $past(res_word)))
        else $error("word location not captured");

    // Reserved nibble bits always zero
    reserved_zero_a: assert property ( // RL10
        rsv_bits == {`NES_SECTORS{1'b0}})
        else $error("reserved status bit set");

    // Lower sectors leave the upper word alone
    low_sector_a: assert property ( // RL1
        (res_valid && !res_sector[`NES_SECTOR_HI_BIT] && quiet)
        |=> $stable(status_word))
        else $error("lower sector changed upper flags");

    // Wide memory forbids the per-sector codes
    wide_page_a: assert property ( // RL11
        (mode_wr && pwdata[`NES_MODE_BUS16])
        |=> ##1 (correction_type_select == nes_pkg::one_code_per_page))
        else $error("wide memory left sector mode on");

    // Error on hole accesses comes back with the answer
    hole_err_a: assert property (
        (setup_ph && !mapped) |=> (pready && pslverr))
        else $error("unmapped access not refused");

    // Low byte lane, the only lane the mode register takes
    wire [`NES_MODE_W-1:0] mode_lane = pwdata[`NES_MODE_W-1:0];

    // One-cycle answer, so one setup never completes twice
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    // Every setup answered in the next cycle
    ready_next_a: assert property (
        setup_ph |=> pready)
        else $error("setup not answered");

    // Error only rides on an answer
    err_with_ready_a: assert property (
        pslverr |-> pready)
        else $error("error without ready");

    // Read data stands until the next setup
    rd_data_hold_a: assert property (
        !setup_ph |=> $stable(prdata))
        else $error("read data moved outside setup");

    // Writes to read-only words and holes are refused
    ro_write_err_a: assert property (
        (setup_ph && pwrite && !sel_mode) |=> pslverr)
        else $error("read-only write not refused");

    // Mode register accesses never refused
    mode_ok_a: assert property (
        (setup_ph && sel_mode) |=> !pslverr)
        else $error("mode access refused");

    // Refused writes leave the mode alone
    ro_write_keep_a: assert property (
        (wr_done && !sel_mode) |=> $stable(mode_reg))
        else $error("refused write changed mode");

    // Accepted mode write lands at the completing edge
    mode_write_a: assert property (
        mode_wr |=> (mode_reg == $past(mode_lane)))
        else $error("mode write lost");

    // Without lane zero the write is dropped
    lane_ignore_a: assert property (
        (wr_done && sel_mode && !pstrb[0]) |=> $stable(mode_reg))
        else $error("mode written without its lane");

    // New page wipes flags and location
    page_clear_a: assert property (
        (page_start && !res_valid)
        |=> ((status_word == 32'h00000000) && (loc_reg == `NES_RST_LOC)))
        else $error("page start left old results");

    // Multiple errors give no usable location, so keep the last one
    multi_keeps_loc_a: assert property ( // RL8
        (res_valid && res_multi && !page_start) |=> $stable(loc_reg))
        else $error("location moved on multiple errors");

    // Location word only serves the one-code-per-page setting
    loc_page_only_a: assert property ( // RL9
        (res_valid && flags_on && !page_start) |=> $stable(loc_reg))
        else $error("location moved in sector mode");

    // Check byte error leaves its one-hot pattern in the low bits
    check_loc_a: assert property ( // RL5
        (page_loc_upd && res_check && !page_start)
        |=> (loc_reg[`NES_CHK_W-1:0] == $past(res_check_pos)))
        else $error("check byte pattern not captured");

    // Effective type is always one of the three codes
    legal_type_a: assert property ( // RL11
        correction_type_select != 2'h3)
        else $error("illegal correction type");

    // Hidden flags while the page code is in use
    page_hides_a: assert property ( // RL2
        !flags_on |-> (status_word == 32'h00000000))
        else $error("flags visible in page mode");

    // Returned flags are gone after the read
    rd_clear_a: assert property (
        (sr2_read_done && !res_valid && !page_start)
        |=> ((status_word & $past(prdata)) == 32'h00000000))
        else $error("read flags not cleared");

    // Location read returns the stored word
    loc_read_a: assert property ( // RL8
        (setup_ph && sel_loc) |=> (prdata == $past(loc_reg)))
        else $error("location read wrong");

    // Status read returns the live flags
    sr2_read_a: assert property ( // RL1
        (setup_ph && sel_sr2) |=> (prdata == $past(status_word)))
        else $error("status read wrong");

    // Mode read returns the stored byte
    mode_read_a: assert property (
        (setup_ph && sel_mode) |=> (prdata[`NES_MODE_W-1:0] == $past(mode_reg)))
        else $error("mode read wrong");

    // Main scenarios
    multi_seen_c: cover property (sector_hit && res_multi && flags_on);
    check_seen_c: cover property (sector_hit && res_check && flags_on);
    sr2_read_c: cover property (sr2_read_done && (prdata != 32'h00000000));
    page_loc_c: cover property (page_loc_upd ##1 (setup_ph && sel_loc));
    lane_skip_c: cover property (wr_done && sel_mode && !pstrb[0]);
endmodule // nes_status

// ---- testbench/nes_engine_model.sv ----
`timescale 1ns/10ps
`include "nes_status_regs.svh"
module nes_engine_model
(
    input wire logic pclk,
    output logic page_start,
    output logic res_valid,
    output logic [3:0] res_sector,
    output logic res_single,
    output logic res_check,
    output logic res_multi,
    output logic [`NES_BIT_W-1:0] res_bit,
    output logic [`NES_WORD_W-1:0] res_word,
    output logic [`NES_CHK_W-1:0] res_check_pos
);
    // Spare area word kept by the host
    logic [31:0] spare_word;

    task automatic store_spare(input logic [31:0] v);
        spare_word = v;
    endtask
    // Quiet engine at time zero
    initial
    begin
        {page_start, res_valid, res_sector, res_single, res_check, res_multi} = '0;
        {res_check_pos, res_word, res_bit} = '0;
        spare_word = '0;
    end

    // One result per edge; a burst ends with idle
    task automatic send(input logic [3:0] s, input logic [2:0] k, input logic [39:0] loc);
        @(posedge pclk);
        res_valid <= 1'b1;
        {res_sector, res_multi, res_check, res_single} <= {s, k};
        {res_check_pos, res_word, res_bit} <= loc;
    endtask

    // Released fields turn to their inverse, so stale values never pass as fresh
    task automatic idle();
        @(posedge pclk);
        res_valid <= 1'b0;
        {res_sector, res_multi, res_check, res_single} <= ~{res_sector, res_multi, res_check, res_single};
        {res_check_pos, res_word, res_bit} <= ~{res_check_pos, res_word, res_bit};
    endtask

    // Start of a new page read
    task automatic new_page();
        @(posedge pclk);
        page_start <= 1'b1;
        @(posedge pclk);
        page_start <= 1'b0;
    endtask
endmodule // nes_engine_model

// ---- testbench/test_nes_status.sv ----
`timescale 1ns/10ps
`include "nes_status_regs.svh"
module test_nes_status;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pstrb, res_sector;
    logic page_start, res_valid, res_single, res_check, res_multi;
    logic [`NES_BIT_W-1:0] res_bit;
    logic [`NES_WORD_W-1:0] res_word;
    logic [`NES_CHK_W-1:0] res_check_pos;
    nes_pkg::nes_corr_e correction_type_select;
    int mismatches, cmp_count, i;
    logic [7:0] modes [5] = '{8'h00, 8'h02, 8'h12, 8'h03, 8'h01};
    logic [1:0] types [5] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h1};

    nes_status nes_status_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .page_start, .res_valid, .res_sector, .res_single,
        .res_check, .res_multi, .res_bit, .res_word, .res_check_pos, .correction_type_select);
    nes_engine_model nes_engine_model_inst (.pclk, .page_start, .res_valid, .res_sector,
        .res_single, .res_check, .res_multi, .res_bit, .res_word, .res_check_pos);

    // 10 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("Compared %0d, mismatched %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp_data(input string name, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_err(input string name, input logic exp, got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [31:0] a, wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a, exp);
        apb(1'b0, a, 32'h0);
        cmp_data(name, exp, rd);
    endtask

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("location reset", `NES_ADDR_LOC, `NES_RST_LOC);
        rd_chk("flags reset", `NES_ADDR_SR2, `NES_RST_SR2);
        rd_chk("mode reset", `NES_ADDR_MODE, 32'h0);
        $display("reset test done");
        // Page mode: flags hidden, location follows single errors
        nes_engine_model_inst.send(4'ha, 3'b001, {24'h0, 12'h5a3, 4'h6});
        nes_engine_model_inst.idle();
        rd_chk("flags page mode", `NES_ADDR_SR2, 32'h0);
        rd_chk("single location", `NES_ADDR_LOC, 32'h00005a36);
        nes_engine_model_inst.send(4'h9, 3'b010, {24'h000400, 16'h0});
        nes_engine_model_inst.send(4'hb, 3'b100, {24'h0, 16'hffff});
        nes_engine_model_inst.idle();
        rd_chk("check byte location", `NES_ADDR_LOC, 32'h00000400);
        nes_engine_model_inst.store_spare(rd);
        cmp_data("spare copy", 32'h00000400, nes_engine_model_inst.spare_word);
        $display("page mode test done");
        // Every correction type, 16-bit memory falls back to page
        for (i = 0; i < 5; i++)
        begin
            apb(1'b1, `NES_ADDR_MODE, {24'h0, modes[i]});
            cmp_err("mode write error", 1'b0, er);
            repeat (2) @(posedge pclk);
            cmp_data("type", {30'h0, types[i]}, {30'h0, correction_type_select});
            rd_chk("mode readback", `NES_ADDR_MODE, {24'h0, modes[i]});
        end
        pstrb <= 4'he;
        apb(1'b1, `NES_ADDR_MODE, 32'h00000002);
        pstrb <= 4'hf;
        cmp_err("lane write error", 1'b0, er);
        rd_chk("mode lane zero only", `NES_ADDR_MODE, 32'h00000001);
        $display("mode test done");
        // Back-to-back sector results, low sector ignored
        nes_engine_model_inst.new_page();
        nes_engine_model_inst.send(4'h8, 3'b001, 40'h0);
        nes_engine_model_inst.send(4'h9, 3'b100, 40'h0);
        nes_engine_model_inst.send(4'hf, 3'b010, 40'h0);
        nes_engine_model_inst.send(4'h3, 3'b100, 40'h0);
        nes_engine_model_inst.idle();
        rd_chk("sector flags", `NES_ADDR_SR2, 32'h20000051);
        rd_chk("flags after read", `NES_ADDR_SR2, 32'h0);
        $display("sector test done");
        // Refused accesses
        apb(1'b1, `NES_ADDR_SR2, 32'hffffffff);
        cmp_err("write read-only", 1'b1, er);
        rd_chk("flags unchanged", `NES_ADDR_SR2, 32'h0);
        apb(1'b0, 32'h400e0040, 32'h0);
        cmp_err("unmapped error", 1'b1, er);
        cmp_data("unmapped data", 32'h0, rd);
        $display("refusal test done");
        end_of_test();
    end
endmodule // test_nes_status
